// ---- impc_core.sv ----
// Interrupt mode, NMI edge and source priority configuration block
`timescale 1ns/1ps
module impc_core (
  input wire logic sys_clk,
  input wire logic rst,
  input wire impc_pkg::impc_wb_req_t wbReq,
  output impc_pkg::impc_wb_rsp_t wbRsp,
  input wire impc_pkg::impc_cpu_in_t cpuIn,
  output logic nmiReq,
  output logic maskableReq,
  output logic [5:0] reqSource,
  output logic [3:0] reqLevel,
  output logic [1:0] controlMode,
  output logic irq
);
  import impc_pkg::*;

  // =============================================================
  // Functions
  function automatic logic [2:0] srcLevel(
    input logic [NUM_PRIO_REGS*16-1:0] regs,
    input int idx
  );
    logic [15:0] word;
    word = regs[(idx/4)*16 +: 16];
    srcLevel = word[(idx%4)*4 +: 3];
  endfunction : srcLevel

  function automatic logic [15:0] merge16(
    input logic [15:0] old,
    input logic [15:0] wdat,
    input logic [1:0] sel
  );
    merge16 = old;
    if (sel[0]) begin
      merge16[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      merge16[15:8] = wdat[15:8];
    end
  endfunction : merge16

  // =============================================================
  // Pin synchroniser and cross-domain inputs
  logic nmiS1_ff, nmiS2_ff, nmiS3_ff;
  logic nxt_nmiS1, nxt_nmiS2, nxt_nmiS3;
  logic [NUM_SOURCES-1:0] reqS1_ff, reqS2_ff;
  logic [NUM_SOURCES-1:0] nxt_reqS1, nxt_reqS2;

  // Plain shift; third stage only for edge detect
  always_comb begin
    nxt_nmiS1 = cpuIn.nmiPin;
    nxt_nmiS2 = nmiS1_ff;
    nxt_nmiS3 = nmiS2_ff;
    nxt_reqS1 = cpuIn.req;
    nxt_reqS2 = reqS1_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmiS1_ff <= 1'b0;
      nmiS2_ff <= 1'b0;
      nmiS3_ff <= 1'b0;
      reqS1_ff <= '0;
      reqS2_ff <= '0;
    end else begin
      nmiS1_ff <= nxt_nmiS1;
      nmiS2_ff <= nxt_nmiS2;
      nmiS3_ff <= nxt_nmiS3;
      reqS1_ff <= nxt_reqS1;
      reqS2_ff <= nxt_reqS2;
    end
  end

  // =============================================================
  // Register bus and configuration state
  logic [7:0] ctrl_ff, nxt_ctrl;
  logic [NUM_PRIO_REGS*16-1:0] prio_ff, nxt_prio;
  logic [2:0] stat_ff, nxt_stat;
  logic [2:0] mask_ff, nxt_mask;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic [2:0] events;
  logic access;
  logic isPrio;
  logic [3:0] prioIdx;
  logic [7:0] relOfs;
  logic [15:0] prioWord;

  assign access = wbReq.cyc & wbReq.stb & ~ack_ff;
  assign relOfs = wbReq.adr - OFS_PRIO_BASE;
  assign prioIdx = relOfs[5:2];
  assign prioWord = prio_ff[prioIdx*16 +: 16];
  assign isPrio = (wbReq.adr >= OFS_PRIO_BASE) &&
                  (wbReq.adr <= OFS_PRIO_LAST) && (wbReq.adr[1:0] == 2'h0);

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_prio = prio_ff;
    nxt_mask = mask_ff;
    nxt_ack = access;
    nxt_rdat = 32'h0;
    nxt_stat = stat_ff;
    if (access && wbReq.we) begin
      if (wbReq.adr == OFS_CTRL && wbReq.sel[0]) begin
        nxt_ctrl = wbReq.dat[7:0];
      end
      if (isPrio) begin
        // Reserved bits kept at zero
        nxt_prio[prioIdx*16 +: 16] =
          merge16(prio_ff[prioIdx*16 +: 16], wbReq.dat[15:0],
                  wbReq.sel[1:0]) & PRIO_WMASK;
      end
      if (wbReq.adr == OFS_IRQ_MASK && wbReq.sel[0]) begin
        nxt_mask = wbReq.dat[2:0];
      end
    end
    if (access && !wbReq.we) begin
      if (wbReq.adr == OFS_CTRL) begin
        nxt_rdat = {24'h0, ctrl_ff};
      end else if (isPrio) begin
        nxt_rdat = {16'h0, prio_ff[prioIdx*16 +: 16]};
      end else if (wbReq.adr == OFS_IRQ_STAT) begin
        nxt_rdat = {29'h0, stat_ff};
        nxt_stat = 3'h0;
      end else if (wbReq.adr == OFS_IRQ_MASK) begin
        nxt_rdat = {29'h0, mask_ff};
      end
    end
    // Set wins over read clear
    nxt_stat = nxt_stat | events;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= CTRL_RESET;
      prio_ff <= {NUM_PRIO_REGS{PRIO_RESET}};
      mask_ff <= STAT_RESET;
      stat_ff <= STAT_RESET;
      ack_ff <= 1'b0;
      rdat_ff <= 32'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      prio_ff <= nxt_prio;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // =============================================================
  // Acceptance logic
  logic [1:0] mode;
  logic edgeRising;
  logic nmiEdge;
  logic nmi_ff, nxt_nmi;
  logic mreq_ff, nxt_mreq;
  logic [5:0] src_ff, nxt_src;
  logic [3:0] lvl_ff, nxt_lvl;
  logic irq_ff, nxt_irq;
  logic badMode;
  logic found;
  logic [2:0] best;

  assign mode = ctrl_ff[CTRL_MODE_LO +: 2];
  assign edgeRising = ctrl_ff[CTRL_EDGE_BIT];
  assign badMode = (mode != MODE_ZERO) && (mode != MODE_TWO);
  assign nmiEdge = edgeRising ? (nmiS2_ff & ~nmiS3_ff) :
                                (~nmiS2_ff & nmiS3_ff);

  always_comb begin
    found = 1'b0;
    best = 3'h0;
    nxt_src = 6'h0;
    nxt_lvl = 4'h0;
    nxt_nmi = nmiEdge;
    for (int i = 0; i < NUM_SOURCES; i++) begin
      if (reqS2_ff[i]) begin
        if (mode == MODE_TWO) begin
          // Higher binary level wins
          if (srcLevel(prio_ff, i) > cpuIn.maskLevel &&
              (!found || srcLevel(prio_ff, i) > best)) begin
            found = 1'b1;
            best = srcLevel(prio_ff, i);
            nxt_src = 6'(i);
          end
        end else if (!cpuIn.globalMask && !found) begin
          found = 1'b1;
          nxt_src = 6'(i);
        end
      end
    end
    nxt_mreq = found & ~badMode;
    nxt_lvl = nmiEdge ? NMI_LEVEL : {1'b0, best};
    events = 3'h0;
    events[EV_NMI] = nmiEdge;
    events[EV_BADMODE] = badMode;
    events[EV_FWD] = found & ~badMode;
    nxt_irq = |(nxt_stat & mask_ff);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nmi_ff <= 1'b0;
      mreq_ff <= 1'b0;
      src_ff <= 6'h0;
      lvl_ff <= 4'h0;
      irq_ff <= 1'b0;
    end else begin
      nmi_ff <= nxt_nmi;
      mreq_ff <= nxt_mreq;
      src_ff <= nxt_src;
      lvl_ff <= nxt_lvl;
      irq_ff <= nxt_irq;
    end
  end

  assign nmiReq = nmi_ff;
  assign maskableReq = mreq_ff;
  assign reqSource = src_ff;
  assign reqLevel = lvl_ff;
  assign controlMode = ctrl_ff[CTRL_MODE_LO +: 2];
  assign irq = irq_ff;
  assign wbRsp.ack = ack_ff;
  assign wbRsp.dat = rdat_ff;

  // =============================================================
  // Assertions: register bus
  ack_answer_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    access |=> wbRsp.ack)
    else $error("request not answered");
  ack_once_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    ack_ff |=> !ack_ff)
    else $error("ack held two cycles");
  ctrl_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (access && wbReq.we && wbReq.adr == OFS_CTRL && wbReq.sel[0])
    |=> ctrl_ff == $past(wbReq.dat[7:0]))
    else $error("control write lost");
  ctrl_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (access && !wbReq.we && wbReq.adr == OFS_CTRL)
    |=> wbRsp.dat == {24'h0, $past(ctrl_ff)})
    else $error("control read wrong");
  prio_resv_zero_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (prio_ff & ~{NUM_PRIO_REGS{PRIO_WMASK}}) == '0)
    else $error("priority reserved bit set");
  prio_read_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (access && !wbReq.we && isPrio)
    |=> wbRsp.dat == {16'h0, $past(prioWord)})
    else $error("priority read wrong");
  prio_write_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (access && wbReq.we && isPrio && wbReq.sel[1:0] == 2'h3)
    |=> prio_ff[$past(prioIdx)*16 +: 16] ==
        ($past(wbReq.dat[15:0]) & PRIO_WMASK))
    else $error("priority write lost");

  // =============================================================
  // Assertions: acceptance
  nmi_edge_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (ctrl_ff[CTRL_EDGE_BIT] && $rose(nmiS2_ff)) |=> nmiReq)
    else $error("nmi rising edge missed");
  nmi_fall_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!ctrl_ff[CTRL_EDGE_BIT] && $fell(nmiS2_ff)) |=> nmiReq)
    else $error("nmi falling edge missed");
  nmi_status_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    nmiEdge |=> stat_ff[EV_NMI])
    else $error("nmi event not recorded");
  nmi_level_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    nmiReq |-> reqLevel == NMI_LEVEL)
    else $error("nmi level not eight");
  nmi_unmasked_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (nmiEdge && cpuIn.globalMask) |=> nmiReq)
    else $error("nmi blocked by mask");
  mode0_mask_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_ZERO && cpuIn.globalMask) |=> !maskableReq)
    else $error("mode 0 request while masked");
  mode0_level_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_ZERO && !nmiEdge) |=> reqLevel == 4'h0)
    else $error("mode 0 level not zero");
  mode2_gate_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_TWO && nxt_mreq) |-> best > cpuIn.maskLevel)
    else $error("level not above mask");
  mode2_pick_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_TWO && nxt_mreq) |=> maskableReq)
    else $error("mode 2 request dropped");
  mode2_level_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    (mode == MODE_TWO && nxt_mreq && !nmiEdge)
    |=> (!reqLevel[3] && reqLevel[2:0] > $past(cpuIn.maskLevel)))
    else $error("forwarded level not above mask");
  bad_mode_a: assert property (
    @(posedge sys_clk) disable iff (rst)
    badMode |=> !maskableReq)
    else $error("prohibited mode forwarded");
endmodule : impc_core

// ---- impc_pkg.sv ----
// Package for the interrupt mode and priority configuration block
package impc_pkg;
  localparam int NUM_PRIO_REGS = 11;
  localparam int NUM_SOURCES = 44;
  // Byte offsets on the register bus
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h04;
  localparam logic [7:0] OFS_PRIO_LAST = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  // Control register fields
  localparam int CTRL_MODE_LO = 4;
  localparam int CTRL_EDGE_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] PRIO_RESET = 16'h7777;
  localparam logic [15:0] PRIO_WMASK = 16'h7777;
  localparam logic [1:0] MODE_ZERO = 2'h0;
  localparam logic [1:0] MODE_TWO = 2'h2;
  localparam logic [3:0] NMI_LEVEL = 4'h8;
  // Interrupt status bits
  localparam int EV_NMI = 0;
  localparam int EV_BADMODE = 1;
  localparam int EV_FWD = 2;
  localparam logic [2:0] STAT_RESET = 3'h0;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } impc_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } impc_wb_rsp_t;

  typedef struct packed {
    logic [NUM_SOURCES-1:0] req;
    logic globalMask;
    logic [2:0] maskLevel;
    logic nmiPin;
  } impc_cpu_in_t;
endpackage : impc_pkg

// ---- impc_cpu_model.sv ----
// CPU core and request source model driving the request inputs
`timescale 1ns/1ps
module impc_cpu_model (
  input wire logic sys_clk,
  input wire logic nmiReq,
  input wire logic [3:0] reqLevel,
  output impc_pkg::impc_cpu_in_t cpuIn
);
  import impc_pkg::*;
  int nmiCount = 0;
  logic [3:0] nmiLvl = 4'h0;
  initial cpuIn = '0;
  // Drive new state, then wait out sync and output stages
  task set(input logic [NUM_SOURCES-1:0] r, input logic gm,
    input logic [2:0] ml, input logic pin);
    @(posedge sys_clk);
    cpuIn <= '{r, gm, ml, pin};
    repeat (6) @(posedge sys_clk);
  endtask : set
  // Count cycles of NMI request, keep its level
  always @(posedge sys_clk) begin
    if (nmiReq === 1'b1) begin
      nmiCount <= nmiCount + 1;
      nmiLvl <= reqLevel;
    end
  end
endmodule : impc_cpu_model

// ---- tb_interrupt_mode_priority_config.sv ----
// Testbench for the interrupt mode and priority configuration block
`timescale 1ns/1ps
module tb_interrupt_mode_priority_config;
  import impc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  impc_wb_req_t wbReq = '0;
  impc_wb_rsp_t wbRsp;
  impc_cpu_in_t cpuIn;
  logic nmiReq;
  logic maskableReq;
  logic irq;
  logic [5:0] reqSource;
  logic [3:0] reqLevel;
  logic [1:0] controlMode;
  logic [31:0] q;
  int nMismatch = 0;
  int checksDone = 0;
  localparam logic [43:0] SRC_LO = 44'h20;
  localparam logic [43:0] SRC_HI = 44'h220;

  always #2 sys_clk = ~sys_clk;

  impc_core uut (.sys_clk(sys_clk), .rst(rst), .wbReq(wbReq),
    .wbRsp(wbRsp), .cpuIn(cpuIn), .nmiReq(nmiReq),
    .maskableReq(maskableReq), .reqSource(reqSource),
    .reqLevel(reqLevel), .controlMode(controlMode), .irq(irq));
  impc_cpu_model cpu (.sys_clk(sys_clk), .nmiReq(nmiReq),
    .reqLevel(reqLevel), .cpuIn(cpuIn));

  // ========
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Classic single cycle, always whole words
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbReq <= '{1'b1, 1'b1, w, 4'hf, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    q = wbRsp.dat;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
  endtask : bus

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  task out(input logic [10:0] e);
    chk({21'h0, maskableReq, reqSource, reqLevel}, {21'h0, e});
  endtask : out

  task endOfTest;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : endOfTest

  // ========
  // Tests
  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(OFS_CTRL, 32'h0);
    rd(OFS_IRQ_STAT, 32'h0);
    rd(8'h40, 32'h0);
    bus(1'b1, 8'h40, 32'h5);
    rd(8'h40, 32'h0);
    bus(1'b1, OFS_CTRL, 32'hc7);
    rd(OFS_CTRL, 32'hc7);
    for (int i = 0; i < NUM_PRIO_REGS; i++) begin
      rd(OFS_PRIO_BASE + 8'(4 * i), 32'h7777);
      bus(1'b1, OFS_PRIO_BASE + 8'(4 * i), 32'habcd);
      rd(OFS_PRIO_BASE + 8'(4 * i), 32'h2345);
    end
    bus(1'b1, 8'h08, 32'h0030);
    bus(1'b1, 8'h0c, 32'h0070);
    // ======== Mode 0
    bus(1'b1, OFS_CTRL, 32'h00);
    cpu.set(SRC_HI, 1'b0, 3'h7, 1'b0);
    out({1'b1, 6'd5, 4'd0});
    cpu.set(SRC_HI, 1'b1, 3'h0, 1'b0);
    chk({31'h0, maskableReq}, 32'h0);
    // ======== Mode 2
    bus(1'b1, OFS_CTRL, 32'h20);
    chk({30'h0, controlMode}, 32'h2);
    cpu.set(SRC_HI, 1'b1, 3'h3, 1'b0);
    out({1'b1, 6'd9, 4'd7});
    cpu.set(SRC_HI, 1'b1, 3'h7, 1'b0);
    chk({31'h0, maskableReq}, 32'h0);
    cpu.set(SRC_HI, 1'b1, 3'h6, 1'b0);
    out({1'b1, 6'd9, 4'd7});
    cpu.set(SRC_LO, 1'b0, 3'h3, 1'b0);
    chk({31'h0, maskableReq}, 32'h0);
    cpu.set(SRC_LO, 1'b0, 3'h2, 1'b0);
    out({1'b1, 6'd5, 4'd3});
    // ======== Prohibited mode forwards no maskable request
    bus(1'b1, OFS_CTRL, 32'h10);
    cpu.set(SRC_LO, 1'b0, 3'h0, 1'b0);
    chk({31'h0, maskableReq}, 32'h0);
    // ======== NMI edges and interrupt
    bus(1'b1, OFS_CTRL, 32'h00);
    cpu.set(44'h0, 1'b1, 3'h7, 1'b0);
    rd(OFS_IRQ_STAT, 32'h6);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    cpu.set(44'h0, 1'b1, 3'h7, 1'b1);
    chk(32'(cpu.nmiCount), 32'h0);
    cpu.set(44'h0, 1'b1, 3'h7, 1'b0);
    chk(32'(cpu.nmiCount), 32'h1);
    chk({28'h0, cpu.nmiLvl}, 32'h8);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1);
    rd(OFS_IRQ_STAT, 32'h1);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h28);
    cpu.set(44'h0, 1'b1, 3'h7, 1'b1);
    chk(32'(cpu.nmiCount), 32'h2);
    cpu.set(44'h0, 1'b1, 3'h7, 1'b0);
    chk(32'(cpu.nmiCount), 32'h2);
    endOfTest;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    nMismatch++;
    endOfTest;
  end
endmodule : tb_interrupt_mode_priority_config
